//--- core/hac_pkg.sv
// constants, layouts and types for the hypervisor auxiliary control bank
// assumes one 100 MHz clock, synchronous reset and an APB master outside
package hac_pkg;

    localparam int HAC_ADDR_W = 8;

    // byte offsets of the bank, one aligned word each
    localparam logic [7:0] HAC_OFS_LEGACY_CSID = 8'h00;
    localparam logic [7:0] HAC_OFS_AUX_CONFIG = 8'h04;
    localparam logic [7:0] HAC_OFS_AUX_CTRL = 8'h08;
    localparam logic [7:0] HAC_OFS_AUX_CTRL_UP = 8'h0C;
    localparam logic [7:0] HAC_OFS_DFAULT_SYN = 8'h10;
    localparam logic [7:0] HAC_OFS_IFAULT_SYN = 8'h14;
    localparam logic [7:0] HAC_OFS_MEM_ATTR_LO = 8'h18;
    localparam logic [7:0] HAC_OFS_MEM_ATTR_HI = 8'h1C;
    localparam logic [7:0] HAC_OFS_DENY_COUNT = 8'h20;

    // control word field positions
    localparam int HAC_BIT_CLUSTER_PERF = 12;
    localparam int HAC_BIT_SCHEME = 11;
    localparam int HAC_BIT_THREAD_SID = 10;
    localparam int HAC_BIT_POWER = 7;
    localparam int HAC_BIT_PSEUDO_FAULT = 5;
    localparam int HAC_BIT_EXT_CTRL = 1;
    localparam int HAC_BIT_AUX_CTRL = 0;

    // writable bits of the control word; everything else is reserved zero
    localparam logic [31:0] HAC_CTRL_WMASK = 32'h00001CA3;
    localparam logic [31:0] HAC_CTRL_RESET = 32'h00000000;
    localparam logic [15:0] HAC_DENY_RESET = 16'h0000;
    localparam logic [15:0] HAC_DENY_MAX = 16'hFFFF;

    // register selector from the address decoder
    typedef enum logic [3:0] {
        HAC_SEL_NONE = 4'h0,
        HAC_SEL_RAZ = 4'h1,
        HAC_SEL_CTRL = 4'h2,
        HAC_SEL_DENY = 4'h3
    } hac_sel_t;

    // gated register groups outside this bank
    typedef enum logic [2:0] {
        HAC_GRP_CLUSTER_PERF = 3'h0,
        HAC_GRP_SCHEME = 3'h1,
        HAC_GRP_THREAD_SID = 3'h2,
        HAC_GRP_POWER = 3'h3,
        HAC_GRP_PSEUDO_FAULT = 3'h4,
        HAC_GRP_EXT_CTRL = 3'h5,
        HAC_GRP_AUX_CTRL = 3'h6
    } hac_group_t;

    // permission question asked by the core's register access path
    typedef struct packed {
        logic valid;
        logic is_write;
        logic [1:0] level;
        logic non_secure;
        logic el2_write_ok;
        hac_group_t group;
    } hac_perm_req_t;

    // one-cycle answer to the question above
    typedef struct packed {
        logic valid;
        logic allowed;
        hac_group_t group;
    } hac_perm_resp_t;

    // enable bits as seen by the gated registers
    typedef struct packed {
        logic cluster_perf_write_enable;
        logic scheme_write_enable;
        logic thread_scheme_id_enable;
        logic power_regs_write_enable;
        logic pseudo_fault_write_enable;
        logic extended_control_write_enable;
        logic aux_control_write_enable;
    } hac_enables_t;

endpackage

//--- core/hac_aux_control_bank.sv
// hypervisor auxiliary control bank: APB slave plus write-permission decision
// assumes an APB master on i_sys_clk and a same-clock permission requester
module hac_aux_control_bank
    import hac_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [HAC_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire hac_perm_req_t i_perm_req,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    output hac_perm_resp_t o_perm_resp,
    output hac_enables_t o_write_enables
);

    // bus handshake states
    typedef enum logic [1:0] {
        HAC_ST_IDLE = 2'b01,
        HAC_ST_ACK = 2'b10
    } hac_state_t;

    // address decode, shared by the read and the write path
    function automatic hac_sel_t hac_decode(input logic [HAC_ADDR_W-1:0] addr);
        hac_sel_t sel;
        sel = HAC_SEL_NONE;
        case (addr)
            HAC_OFS_LEGACY_CSID: sel = HAC_SEL_RAZ;
            HAC_OFS_AUX_CONFIG: sel = HAC_SEL_RAZ;
            HAC_OFS_AUX_CTRL: sel = HAC_SEL_CTRL;
            HAC_OFS_AUX_CTRL_UP: sel = HAC_SEL_RAZ;
            HAC_OFS_DFAULT_SYN: sel = HAC_SEL_RAZ;
            HAC_OFS_IFAULT_SYN: sel = HAC_SEL_RAZ;
            HAC_OFS_MEM_ATTR_LO: sel = HAC_SEL_RAZ;
            HAC_OFS_MEM_ATTR_HI: sel = HAC_SEL_RAZ;
            HAC_OFS_DENY_COUNT: sel = HAC_SEL_DENY;
            default: sel = HAC_SEL_NONE;
        endcase
        return sel;
    endfunction

    hac_state_t state;
    hac_state_t next_state;
    logic next_pready;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic [31:0] aux_ctrl;
    logic [31:0] next_aux_ctrl;
    hac_enables_t next_write_enables;
    logic [15:0] deny_count;
    logic [15:0] next_deny_count;
    hac_perm_resp_t next_perm_resp;
    hac_sel_t sel;
    logic [31:0] byte_mask;
    logic bus_write;
    logic el2_ok;
    logic grp_en;
    logic gated;
    logic allowed;

    // decode and write qualifier of the current request
    assign sel = hac_decode(i_paddr);
    assign bus_write = (state == HAC_ST_ACK) && i_psel && i_penable && i_pwrite;

    // expand pstrb into a bit mask, one lane per byte
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            assign byte_mask[lane*8 +: 8] = {8{i_pstrb[lane]}};
        end
    endgenerate

    // bus handshake: one wait state, pready stands for one cycle only
    always_comb begin
        next_state = state;
        next_pready = 1'b0;
        next_prdata = o_prdata;
        next_pslverr = 1'b0;
        case (state)
            HAC_ST_IDLE: begin
                if (i_psel && i_penable) begin
                    next_pready = 1'b1;
                    next_state = HAC_ST_ACK;
                    next_prdata = 32'h00000000;
                    next_pslverr = (sel == HAC_SEL_NONE);
                    if (!i_pwrite) begin
                        case (sel)
                            HAC_SEL_CTRL: next_prdata = aux_ctrl & HAC_CTRL_WMASK;
                            HAC_SEL_DENY: next_prdata = {16'h0000, deny_count};
                            // the upper word keeps no state, so its undefined reset
                            // value can never surface on a read
                            HAC_SEL_RAZ: next_prdata = 32'h00000000;
                            default: next_prdata = 32'h00000000;
                        endcase
                    end
                end
            end
            HAC_ST_ACK: begin
                next_state = HAC_ST_IDLE;
            end
            default: begin
                next_state = HAC_ST_IDLE;
            end
        endcase
    end

    // control word: written only on the edge that samples pready high
    always_comb begin
        next_aux_ctrl = aux_ctrl;
        if (bus_write && sel == HAC_SEL_CTRL) begin
            // reserved bits are dropped so they always read back zero
            next_aux_ctrl = ((aux_ctrl & ~byte_mask) | (i_pwdata & byte_mask))
                & HAC_CTRL_WMASK;
        end
        next_write_enables.cluster_perf_write_enable =
            next_aux_ctrl[HAC_BIT_CLUSTER_PERF];
        next_write_enables.scheme_write_enable = next_aux_ctrl[HAC_BIT_SCHEME];
        next_write_enables.thread_scheme_id_enable = next_aux_ctrl[HAC_BIT_THREAD_SID];
        next_write_enables.power_regs_write_enable = next_aux_ctrl[HAC_BIT_POWER];
        next_write_enables.pseudo_fault_write_enable =
            next_aux_ctrl[HAC_BIT_PSEUDO_FAULT];
        next_write_enables.extended_control_write_enable =
            next_aux_ctrl[HAC_BIT_EXT_CTRL];
        next_write_enables.aux_control_write_enable = next_aux_ctrl[HAC_BIT_AUX_CTRL];
    end

    // level 2 write right: the bank decides for scheme, thread ID and pseudo-fault groups,
    // for the rest the requester reports what its own level 2 control says
    always_comb begin
        case (i_perm_req.group)
            HAC_GRP_SCHEME: el2_ok = aux_ctrl[HAC_BIT_SCHEME];
            HAC_GRP_THREAD_SID: el2_ok = aux_ctrl[HAC_BIT_SCHEME];
            HAC_GRP_PSEUDO_FAULT: el2_ok = aux_ctrl[HAC_BIT_PSEUDO_FAULT];
            default: el2_ok = i_perm_req.el2_write_ok;
        endcase
    end

    // level 1 enable bit of each group; the scheme group has no level 1 path
    always_comb begin
        case (i_perm_req.group)
            HAC_GRP_CLUSTER_PERF: grp_en = aux_ctrl[HAC_BIT_CLUSTER_PERF];
            HAC_GRP_THREAD_SID: grp_en = aux_ctrl[HAC_BIT_THREAD_SID];
            HAC_GRP_POWER: grp_en = aux_ctrl[HAC_BIT_POWER];
            HAC_GRP_PSEUDO_FAULT: grp_en = aux_ctrl[HAC_BIT_PSEUDO_FAULT];
            HAC_GRP_EXT_CTRL: grp_en = aux_ctrl[HAC_BIT_EXT_CTRL];
            HAC_GRP_AUX_CTRL: grp_en = aux_ctrl[HAC_BIT_AUX_CTRL];
            default: grp_en = 1'b0;
        endcase
    end

    // decision: writes are gated at levels 1 and 2, the thread ID register also on level 1 reads; level 0 is always refused, reads too
    always_comb begin
        gated = i_perm_req.is_write || (i_perm_req.group == HAC_GRP_THREAD_SID);
        case (i_perm_req.level)
            2'h3: allowed = 1'b1;
            2'h2: allowed = !i_perm_req.is_write || el2_ok;
            // secure level 1 never gains access through this word
            2'h1: allowed = !gated || (i_perm_req.non_secure && grp_en && el2_ok);
            default: allowed = 1'b0;
        endcase
    end

    // answer one cycle after the question; count refused writes for software
    always_comb begin
        next_perm_resp.valid = i_perm_req.valid;
        next_perm_resp.allowed = i_perm_req.valid && allowed;
        next_perm_resp.group = i_perm_req.group;
        next_deny_count = deny_count;
        // a denied write must leave the target untouched, so it is only counted
        if (i_perm_req.valid && i_perm_req.is_write && !allowed &&
            deny_count != HAC_DENY_MAX) begin
            next_deny_count = deny_count + 16'h0001;
        end
    end

    // bus state registers
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            state <= HAC_ST_IDLE;
            o_pready <= 1'b0;
            o_prdata <= 32'h00000000;
            o_pslverr <= 1'b0;
        end else begin
            state <= next_state;
            o_pready <= next_pready;
            o_prdata <= next_prdata;
            o_pslverr <= next_pslverr;
        end
    end

    // control word and its mirrored enable outputs
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            aux_ctrl <= HAC_CTRL_RESET;
            o_write_enables <= '0;
        end else begin
            aux_ctrl <= next_aux_ctrl;
            o_write_enables <= next_write_enables;
        end
    end

    // permission answer and refusal counter
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_perm_resp <= '0;
            deny_count <= HAC_DENY_RESET;
        end else begin
            o_perm_resp <= next_perm_resp;
            deny_count <= next_deny_count;
        end
    end

endmodule

//--- bench/hac_bank_asserts.sv
// port checker for the aux control bank
// assumes a bind from tb_top; one clock, sync reset
module hac_bank_asserts
    import hac_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [HAC_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire hac_perm_req_t i_perm_req,
    input wire logic o_pready,
    input wire logic [31:0] o_prdata,
    input wire logic o_pslverr,
    input wire hac_perm_resp_t o_perm_resp,
    input wire hac_enables_t o_write_enables
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);
    // read answers on a read strobe of the given word
    logic rd_ack;
    assign rd_ack = o_pready && !i_pwrite;
    // one wait state, then a single-cycle ready
    a_ready_one_wait: assert property ($rose(i_penable) && i_psel |=> o_pready ##1 !o_pready)
        else $error("ready timing wrong");
    a_slverr_with_ready: assert property (o_pslverr |-> o_pready)
        else $error("slverr without ready");
    a_ctrl_rsvd_zero: assert property (
        rd_ack && i_paddr == HAC_OFS_AUX_CTRL |-> (o_prdata & ~HAC_CTRL_WMASK) == 32'h0)
        else $error("reserved control bits set");
    a_raz_words_zero: assert property (
        rd_ack && i_paddr != HAC_OFS_AUX_CTRL && i_paddr != HAC_OFS_DENY_COUNT |-> o_prdata == 0)
        else $error("reserved word not zero");
    a_resp_one_cycle: assert property (i_perm_req.valid |=> o_perm_resp.valid)
        else $error("answer missing");
    a_resp_has_cause: assert property (o_perm_resp.valid |-> $past(i_perm_req.valid))
        else $error("answer without question");
    a_group_echo: assert property (i_perm_req.valid |=> o_perm_resp.group == $past(i_perm_req.group))
        else $error("group not echoed");
    a_level3_free: assert property (i_perm_req.valid && i_perm_req.level == 2'h3
        |=> o_perm_resp.allowed) else $error("level 3 refused");
    a_pf_gate_off: assert property (i_perm_req.valid && i_perm_req.level == 2'h1
        && i_perm_req.group == HAC_GRP_PSEUDO_FAULT && !o_write_enables.pseudo_fault_write_enable
        |=> !o_perm_resp.allowed) else $error("pseudo fault write let through");
    c_refused: cover property (i_perm_req.valid ##1 !o_perm_resp.allowed);
    c_allowed: cover property (i_perm_req.valid && i_perm_req.level == 2'h1 ##1 o_perm_resp.allowed);
    c_unmapped: cover property (o_pslverr);
endmodule

//--- bench/tb_top.sv
// self-checking bench for the aux control bank
// assumes hac_pkg, the bank and its checker compiled first
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import hac_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    hac_perm_req_t req = '0;
    hac_perm_resp_t resp;
    hac_enables_t wen;
    int n_errors = 0;
    int num_checks = 0;
    int n_ref = 0;
    always #5 clk = ~clk;
    hac_aux_control_bank i_dut (.i_sys_clk(clk), .i_reset(rst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
        .i_perm_req(req), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .o_perm_resp(resp), .o_write_enables(wen));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s exp %h got %h", what, exp, got);
        end
    endtask
    // one apb transfer; an idle edge first so release and setup never share a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic err);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        // a slave that never answers is a failure, not a silent pass
        if (i == 20) begin
            n_errors++;
            report_and_stop();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] exp, input logic ee);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(n, exp, q);
        chk("slverr", {31'h0, ee}, {31'h0, e});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
        chk("wr slverr", 32'h0, {31'h0, e});
    endtask
    // any permission question, answer sampled one cycle on; refused writes are tallied
    task automatic ask_any(input logic [1:0] lvl, input logic ns, input hac_group_t g,
            input logic w, input logic e2, input logic ok);
        @(posedge clk);
        req <= '{1'b1, w, lvl, ns, e2, g};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
        chk("perm", {27'h0, 1'b1, ok, g}, {27'h0, resp.valid, resp.allowed, resp.group});
        n_ref += int'(w && !ok);
    endtask
    // write question with the requester's own level 2 right granted
    task automatic ask(input logic [1:0] lvl, input logic ns, input hac_group_t g, input logic ok);
        ask_any(lvl, ns, g, 1'b1, 1'b1, ok);
    endtask
    initial begin
        #200000;
        // running out of time counts as a mismatch
        n_errors++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdc("ctrl", HAC_OFS_AUX_CTRL, 32'h0, 1'b0);
        chk("enables", 32'h0, {25'h0, wen});
        for (int k = 0; k < 8; k++) begin
            wr(8'(k * 4), 32'hFFFFFFFF);
            if (k != 2)
                rdc("raz word", 8'(k * 4), 32'h0, 1'b0);
        end
        rdc("ctrl", HAC_OFS_AUX_CTRL, 32'h00001CA3, 1'b0);
        chk("enables", 32'h7F, {25'h0, wen});
        pstrb <= 4'h1;
        wr(HAC_OFS_AUX_CTRL, 32'h0);
        rdc("ctrl lane", HAC_OFS_AUX_CTRL, 32'h00001C00, 1'b0);
        pstrb <= 4'hF;
        wr(HAC_OFS_AUX_CTRL, 32'h0);
        rdc("unmapped", 8'h24, 32'h0, 1'b1);
        $display("register tests done");
        // all gates shut: no level 1 write, scheme shut at level 2
        for (int g = 0; g < 7; g++)
            ask(2'd1, 1'b1, hac_group_t'(g), 1'b0);
        ask(2'd2, 1'b1, HAC_GRP_SCHEME, 1'b0);
        ask(2'd3, 1'b0, HAC_GRP_PSEUDO_FAULT, 1'b1);
        ask(2'h2, 1'b1, HAC_GRP_PSEUDO_FAULT, 1'b0);
        ask_any(2'h1, 1'b1, HAC_GRP_THREAD_SID, 1'b0, 1'b1, 1'b0);
        ask_any(2'h1, 1'b1, HAC_GRP_POWER, 1'b0, 1'b1, 1'b1);
        wr(HAC_OFS_AUX_CTRL, 32'h00001CA3);
        for (int g = 0; g < 7; g++)
            ask(2'd1, 1'b1, hac_group_t'(g), g != 1);
        ask(2'd2, 1'b1, HAC_GRP_SCHEME, 1'b1);
        ask(2'd1, 1'b0, HAC_GRP_AUX_CTRL, 1'b0);
        ask_any(2'h1, 1'b1, HAC_GRP_THREAD_SID, 1'b0, 1'b1, 1'b1);
        ask_any(2'h1, 1'b1, HAC_GRP_POWER, 1'b1, 1'b0, 1'b0);
        ask_any(2'h0, 1'b1, HAC_GRP_AUX_CTRL, 1'b1, 1'b1, 1'b0);
        ask_any(2'h2, 1'b1, HAC_GRP_EXT_CTRL, 1'b0, 1'b0, 1'b1);
        rdc("refusals", HAC_OFS_DENY_COUNT, 32'(n_ref), 1'b0);
        $display("permission tests done");
        // reset in mid-run clears the control word again
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc("ctrl", HAC_OFS_AUX_CTRL, 32'h0, 1'b0);
        chk("enables", 32'h0, {25'h0, wen});
        rdc("refusals", HAC_OFS_DENY_COUNT, 32'h0, 1'b0);
        $display("reset test done");
        report_and_stop();
    end
endmodule
bind hac_aux_control_bank hac_bank_asserts u_chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .i_perm_req(i_perm_req), .o_pready(o_pready),
    .o_prdata(o_prdata), .o_pslverr(o_pslverr), .o_perm_resp(o_perm_resp),
    .o_write_enables(o_write_enables));
